// ===== shared/peis_pkg.sv
// Package: register map, reset values and pin carriers for the port block
// Overview of operation
// [R1] Interrupt line 0 requests pass only while the enable bit is set.
// [R2] Flag sets when the pin is routed as interrupt and its edge arrives.
// [R3] Software clears the flag by writing 0 after reading it as 1.
// [R4] Pin-function value 10h turns port 1 bit 4 into interrupt line 0.
// [R5] Port 1 direction 00h makes all port 1 pins undriven inputs.
// [R6] Port 5 direction FFh drives all port 5 pins with port 5 data.
// [R7] Request stays asserted while flag and enable are both set.
package peis_pkg;

   localparam int PEIS_AW = 16;
   localparam int PEIS_DW = 8;

   localparam logic [15:0] PEIS_OFS_P1_DATA = 16'hFFD4;
   localparam logic [15:0] PEIS_OFS_P5_DATA = 16'hFFD8;
   localparam logic [15:0] PEIS_OFS_P7_DATA = 16'hFFDA;
   localparam logic [15:0] PEIS_OFS_P1_FUNC = 16'hFFE0;
   localparam logic [15:0] PEIS_OFS_P1_DIR = 16'hFFE4;
   localparam logic [15:0] PEIS_OFS_P5_DIR = 16'hFFE8;
   localparam logic [15:0] PEIS_OFS_IRQ_EN = 16'hFFF4;
   localparam logic [15:0] PEIS_OFS_IRQ_FLAGS = 16'hFFF6;

   localparam int PEIS_EXTERNAL_INTERRUPT_LINE_0_BIT = 0;
   localparam int PEIS_EXTERNAL_INTERRUPT_LINE_0_PIN = 4;
   localparam logic [7:0] PEIS_FUNC_EXTERNAL_INTERRUPT_LINE_0 = 8'h10;
   localparam logic [7:0] PEIS_DIR_ALL_IN = 8'h00;
   localparam logic [7:0] PEIS_DIR_ALL_OUT = 8'hFF;

   localparam logic [7:0] PEIS_RST_REG = 8'h00;
   localparam logic [7:0] PEIS_RD_UNMAPPED = 8'h00;

   // Driven side of one 8-bit two-way port
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } peis_drive_t;

endpackage

// ===== tb/peis_switch.sv
// Switch and LED side of ports 1 and 5: resolves each pin level
`timescale 1ns/1ps
`default_nettype none

module peis_switch
   import peis_pkg::*;
(
   // Drive from the block
   input wire peis_drive_t port1_drv,
   input wire peis_drive_t port5_drv,
   // Switch levels where nobody drives
   input wire logic [7:0] sw1,
   input wire logic [7:0] sw5,
   // Pin levels back to the block
   output logic [7:0] port1_in,
   output logic [7:0] port5_in
);
   // Undriven pins follow the switch, driven pins the block
   assign port1_in = (port1_drv.oe & port1_drv.out) | (~port1_drv.oe & sw1);
   assign port5_in = (port5_drv.oe & port5_drv.out) | (~port5_drv.oe & sw5);
endmodule

`default_nettype wire

// ===== tb/port_and_ext_irq_setup_tb.sv
// Testbench for the port registers and interrupt line 0
`timescale 1ns/1ps
`default_nettype none

module port_and_ext_irq_setup_tb;
   import peis_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata, port1_in, port5_in, port7_out;
   peis_drive_t port1_drv, port5_drv;
   logic external_interrupt_line_0_request;
   logic [7:0] sw1 = 8'hFF;
   logic [7:0] sw5 = 8'h3C;
   int n_mismatch = 0;
   int n_checks = 0;

   always #2 clk_sys = ~clk_sys;

   peis_top u_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .port1_in(port1_in), .port1_drv(port1_drv),
      .port5_in(port5_in), .port5_drv(port5_drv), .port7_out(port7_out),
      .external_interrupt_line_0_request(external_interrupt_line_0_request));

   peis_switch u_sw (.port1_drv(port1_drv), .port5_drv(port5_drv),
      .sw1(sw1), .sw5(sw5), .port1_in(port1_in), .port5_in(port5_in));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk({8'h00, reg_rdata}, {8'h00, exp});
   endtask

   // Flag read and clearing write with no gap between the strobes
   task automatic rd_clr(input logic [7:0] exp);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= PEIS_OFS_IRQ_FLAGS;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      reg_wr <= 1'b1;
      reg_wdata <= 8'h00;
      #1;
      chk({8'h00, reg_rdata}, {8'h00, exp});
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask

   // Pin held long enough for the edge detector to see it
   task automatic pin(input logic v);
      @(posedge clk_sys);
      sw1[PEIS_EXTERNAL_INTERRUPT_LINE_0_PIN] <= v;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask

   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      #20000;
      n_mismatch++;
      finish_test;
   end

   initial begin
      repeat (8) @(posedge clk_sys);
      nrst <= 1'b1;
      rd(PEIS_OFS_P7_DATA, 8'h00);
      rd(PEIS_OFS_IRQ_EN, 8'h00);
      rd(PEIS_OFS_IRQ_FLAGS, 8'h00);
      rd(16'hFFF0, PEIS_RD_UNMAPPED);
      chk({15'h0000, external_interrupt_line_0_request}, 16'h0000);
      $display("Test reset values done");
      wr(PEIS_OFS_P1_DATA, 8'h55);
      chk({8'h00, port1_drv.oe}, 16'h0000);
      rd(PEIS_OFS_P1_DATA, 8'hFF);
      wr(PEIS_OFS_P5_DIR, PEIS_DIR_ALL_OUT);
      wr(PEIS_OFS_P5_DATA, 8'hA5);
      chk({port5_drv.oe, port5_drv.out}, 16'hFFA5);
      rd(PEIS_OFS_P5_DATA, 8'hA5);
      wr(PEIS_OFS_P7_DATA, 8'h0C);
      chk({8'h00, port7_out}, 16'h000C);
      $display("Test ports done");
      pin(1'b0);
      pin(1'b1);
      rd(PEIS_OFS_IRQ_FLAGS, 8'h00);
      wr(PEIS_OFS_P1_FUNC, PEIS_FUNC_EXTERNAL_INTERRUPT_LINE_0);
      wr(PEIS_OFS_P1_DIR, PEIS_DIR_ALL_OUT);
      chk({8'h00, port1_drv.oe}, 16'h00EF);
      pin(1'b0);
      chk({15'h0000, external_interrupt_line_0_request}, 16'h0000);
      rd(PEIS_OFS_IRQ_FLAGS, 8'h01);
      wr(PEIS_OFS_IRQ_EN, 8'hFF);
      chk({15'h0000, external_interrupt_line_0_request}, 16'h0001);
      rd(PEIS_OFS_IRQ_EN, 8'h01);
      wr(PEIS_OFS_IRQ_EN, 8'h00);
      chk({15'h0000, external_interrupt_line_0_request}, 16'h0000);
      wr(PEIS_OFS_IRQ_EN, 8'h01);
      wr(PEIS_OFS_IRQ_FLAGS, 8'h00);
      rd(PEIS_OFS_IRQ_FLAGS, 8'h00);
      chk({15'h0000, external_interrupt_line_0_request}, 16'h0000);
      pin(1'b1);
      pin(1'b0);
      chk({15'h0000, external_interrupt_line_0_request}, 16'h0001);
      // Clear without a prior read must not take
      wr(PEIS_OFS_IRQ_FLAGS, 8'h00);
      rd(PEIS_OFS_IRQ_FLAGS, 8'h01);
      wr(PEIS_OFS_IRQ_FLAGS, 8'h00);
      rd(PEIS_OFS_IRQ_FLAGS, 8'h00);
      pin(1'b1);
      pin(1'b0);
      rd_clr(8'h01);
      rd(PEIS_OFS_IRQ_FLAGS, 8'h00);
      chk({15'h0000, external_interrupt_line_0_request}, 16'h0000);
      $display("Test interrupt line done");
      finish_test;
   end
endmodule

`default_nettype wire

// ===== verilog/peis_top.sv
// Port 1/5/7 registers with external interrupt line 0 on port 1 bit 4
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module peis_top
   import peis_pkg::*;
#(
   parameter logic irq_rising_edge = 1'b0
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Register port
   input wire logic [PEIS_AW-1:0] reg_addr,
   input wire logic [PEIS_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [PEIS_DW-1:0] reg_rdata,
   // Port 1 pins
   input wire logic [7:0] port1_in,
   output peis_drive_t port1_drv,
   // Port 5 pins
   input wire logic [7:0] port5_in,
   output peis_drive_t port5_drv,
   // Port 7 outputs (LED)
   output logic [7:0] port7_out,
   // Interrupt request to the processor
   output logic external_interrupt_line_0_request
);

   if (PEIS_DW != 8) begin : g_width_check
      $error("peis_top serves only 8-bit registers");
   end

   // Read view of a port: output bits show the latch, inputs the pin
   function automatic logic [7:0] port_view(input logic [7:0] dir,
         input logic [7:0] data, input logic [7:0] pin);
      port_view = (dir & data) | (~dir & pin);
   endfunction

   function automatic logic hit(input logic [PEIS_AW-1:0] a,
         input logic [15:0] ofs);
      hit = (a == ofs);
   endfunction

   logic [7:0] port1_data;
   logic [7:0] port5_data;
   logic [7:0] port7_data;
   logic [7:0] port1_pin_function;
   logic [7:0] port1_direction;
   logic [7:0] port5_direction;
   logic external_interrupt_line_0_enable_bit;
   logic external_interrupt_line_0_flag;
   logic flag_seen_set;
   logic pin_prev;
   logic [7:0] rdata;

   logic [7:0] next_port1_data;
   logic [7:0] next_port5_data;
   logic [7:0] next_port7_data;
   logic [7:0] next_port1_pin_function;
   logic [7:0] next_port1_direction;
   logic [7:0] next_port5_direction;
   logic next_external_interrupt_line_0_enable_bit;
   logic next_external_interrupt_line_0_flag;
   logic next_flag_seen_set;
   logic next_pin_prev;
   logic [7:0] next_rdata;

   logic irq_pin_sel;
   logic irq_pin;
   logic irq_edge;
   logic flag_clear;

   // Pin routing and edge detection
   always_comb begin
      irq_pin_sel = (port1_pin_function == PEIS_FUNC_EXTERNAL_INTERRUPT_LINE_0); // [R4]
      irq_pin = port1_in[PEIS_EXTERNAL_INTERRUPT_LINE_0_PIN];
      next_pin_prev = irq_pin;
      if (irq_rising_edge) begin
         irq_edge = irq_pin_sel & irq_pin & ~pin_prev; // [R2]
      end else begin
         irq_edge = irq_pin_sel & ~irq_pin & pin_prev; // [R2]
      end
   end

   // Register file next state
   always_comb begin
      next_port1_data = port1_data;
      next_port5_data = port5_data;
      next_port7_data = port7_data;
      next_port1_pin_function = port1_pin_function;
      next_port1_direction = port1_direction;
      next_port5_direction = port5_direction;
      next_external_interrupt_line_0_enable_bit = external_interrupt_line_0_enable_bit;
      next_flag_seen_set = flag_seen_set;
      next_rdata = PEIS_RD_UNMAPPED;
      flag_clear = 1'b0;
      if (reg_wr) begin
         if (hit(reg_addr, PEIS_OFS_P1_DATA)) begin
            next_port1_data = reg_wdata;
         end
         if (hit(reg_addr, PEIS_OFS_P5_DATA)) begin
            next_port5_data = reg_wdata;
         end
         if (hit(reg_addr, PEIS_OFS_P7_DATA)) begin
            next_port7_data = reg_wdata;
         end
         if (hit(reg_addr, PEIS_OFS_P1_FUNC)) begin
            next_port1_pin_function = reg_wdata;
         end
         if (hit(reg_addr, PEIS_OFS_P1_DIR)) begin
            next_port1_direction = reg_wdata;
         end
         if (hit(reg_addr, PEIS_OFS_P5_DIR)) begin
            next_port5_direction = reg_wdata;
         end
         if (hit(reg_addr, PEIS_OFS_IRQ_EN)) begin
            next_external_interrupt_line_0_enable_bit = reg_wdata[PEIS_EXTERNAL_INTERRUPT_LINE_0_BIT]; // [R1]
         end
         if (hit(reg_addr, PEIS_OFS_IRQ_FLAGS)) begin
            // Writing 1 leaves the flag but cancels a prior read of 1; 0 clears only after a read of 1
            flag_clear = flag_seen_set & ~reg_wdata[PEIS_EXTERNAL_INTERRUPT_LINE_0_BIT]; // [R3]
            next_flag_seen_set = 1'b0;
         end
      end
      if (reg_rd) begin
         if (hit(reg_addr, PEIS_OFS_P1_DATA)) begin
            next_rdata = port_view(port1_direction, port1_data, port1_in);
         end
         if (hit(reg_addr, PEIS_OFS_P5_DATA)) begin
            next_rdata = port_view(port5_direction, port5_data, port5_in);
         end
         if (hit(reg_addr, PEIS_OFS_P7_DATA)) begin
            next_rdata = port7_data;
         end
         if (hit(reg_addr, PEIS_OFS_P1_FUNC)) begin
            next_rdata = port1_pin_function;
         end
         if (hit(reg_addr, PEIS_OFS_P1_DIR)) begin
            next_rdata = port1_direction;
         end
         if (hit(reg_addr, PEIS_OFS_P5_DIR)) begin
            next_rdata = port5_direction;
         end
         if (hit(reg_addr, PEIS_OFS_IRQ_EN)) begin
            next_rdata = {7'h00, external_interrupt_line_0_enable_bit};
         end
         if (hit(reg_addr, PEIS_OFS_IRQ_FLAGS)) begin
            next_rdata = {7'h00, external_interrupt_line_0_flag};
            if (external_interrupt_line_0_flag) begin
               next_flag_seen_set = 1'b1; // [R3]
            end
         end
      end
      // A new edge wins over a clear in the same cycle
      if (irq_edge) begin
         next_external_interrupt_line_0_flag = 1'b1; // [R2]
      end else if (flag_clear) begin
         next_external_interrupt_line_0_flag = 1'b0; // [R3]
      end else begin
         next_external_interrupt_line_0_flag = external_interrupt_line_0_flag;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         port1_data <= PEIS_RST_REG;
         port5_data <= PEIS_RST_REG;
         port7_data <= PEIS_RST_REG;
         port1_pin_function <= PEIS_RST_REG;
         port1_direction <= PEIS_RST_REG;
         port5_direction <= PEIS_RST_REG;
         external_interrupt_line_0_enable_bit <= 1'b0;
         external_interrupt_line_0_flag <= 1'b0;
         flag_seen_set <= 1'b0;
         pin_prev <= 1'b0;
         rdata <= PEIS_RD_UNMAPPED;
      end else begin
         port1_data <= next_port1_data;
         port5_data <= next_port5_data;
         port7_data <= next_port7_data;
         port1_pin_function <= next_port1_pin_function;
         port1_direction <= next_port1_direction;
         port5_direction <= next_port5_direction;
         external_interrupt_line_0_enable_bit <= next_external_interrupt_line_0_enable_bit;
         external_interrupt_line_0_flag <= next_external_interrupt_line_0_flag;
         flag_seen_set <= next_flag_seen_set;
         pin_prev <= next_pin_prev;
         rdata <= next_rdata;
      end
   end

   // Pin drive: enables follow direction bits straight from flops, except the routed interrupt pin on port 1
   always_comb begin
      port1_drv.out = port1_data;
      port1_drv.oe = port1_direction; // [R5]
      // Routed interrupt pin is never driven, whatever its direction bit
      if (irq_pin_sel) begin
         port1_drv.oe[PEIS_EXTERNAL_INTERRUPT_LINE_0_PIN] = 1'b0; // [R4]
      end
      port5_drv.out = port5_data; // [R6]
      port5_drv.oe = port5_direction; // [R6]
      port7_out = port7_data;
      reg_rdata = rdata;
      external_interrupt_line_0_request = external_interrupt_line_0_flag & external_interrupt_line_0_enable_bit; // [R1] [R7]
   end

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   sequence flag_read_one;
      reg_rd && hit(reg_addr, PEIS_OFS_IRQ_FLAGS) && external_interrupt_line_0_flag;
   endsequence

   sequence flag_write_zero;
      reg_wr && hit(reg_addr, PEIS_OFS_IRQ_FLAGS)
         && !reg_wdata[PEIS_EXTERNAL_INTERRUPT_LINE_0_BIT] && !irq_edge;
   endsequence

   enable_gates_irq_a: assert property ( // [R1]
      !external_interrupt_line_0_enable_bit |-> !external_interrupt_line_0_request)
      else $error("request passed while enable bit is 0");

   edge_sets_flag_a: assert property ( // [R2]
      irq_pin_sel && (irq_pin != $past(irq_pin))
      && (irq_pin == irq_rising_edge) |=> external_interrupt_line_0_flag)
      else $error("selected edge did not set the flag");

   read_then_clear_a: assert property ( // [R3]
      flag_read_one ##1 (!irq_edge && !reg_rd)[*1] ##0 flag_write_zero
      |=> !external_interrupt_line_0_flag)
      else $error("flag not cleared after read 1 then write 0");

   unrouted_no_flag_a: assert property ( // [R4]
      !external_interrupt_line_0_flag && !irq_pin_sel |=> !external_interrupt_line_0_flag)
      else $error("flag set while pin not routed to interrupt");

   port1_inputs_a: assert property ( // [R5]
      port1_direction == PEIS_DIR_ALL_IN |-> port1_drv.oe == 8'h00)
      else $error("port 1 driven with direction 00h");

   port5_outputs_a: assert property ( // [R6]
      port5_direction == PEIS_DIR_ALL_OUT |->
      port5_drv.oe == 8'hFF && port5_drv.out == port5_data)
      else $error("port 5 not driving its data with direction FFh");

   request_holds_a: assert property ( // [R7]
      external_interrupt_line_0_request && external_interrupt_line_0_enable_bit && !flag_clear
      && !(reg_wr && hit(reg_addr, PEIS_OFS_IRQ_EN)
      && !reg_wdata[PEIS_EXTERNAL_INTERRUPT_LINE_0_BIT]) |=> external_interrupt_line_0_request)
      else $error("request dropped while flag and enable still set");

   // Flag only falls on a write of 0 to the flag register
   flag_holds_a: assert property ( // [R3]
      external_interrupt_line_0_flag && !(reg_wr && hit(reg_addr, PEIS_OFS_IRQ_FLAGS)
      && !reg_wdata[PEIS_EXTERNAL_INTERRUPT_LINE_0_BIT]) |=> external_interrupt_line_0_flag)
      else $error("flag fell without a clearing write");

   flag_read_a: assert property ( // [R2]
      reg_rd && hit(reg_addr, PEIS_OFS_IRQ_FLAGS)
      |=> reg_rdata == {7'h00, $past(external_interrupt_line_0_flag)})
      else $error("flag register read back wrong");

   enable_write_a: assert property ( // [R1]
      reg_wr && hit(reg_addr, PEIS_OFS_IRQ_EN)
      |=> external_interrupt_line_0_enable_bit == $past(reg_wdata[PEIS_EXTERNAL_INTERRUPT_LINE_0_BIT]))
      else $error("enable bit did not take the written value");

   enable_read_a: assert property ( // [R1]
      reg_rd && hit(reg_addr, PEIS_OFS_IRQ_EN)
      |=> reg_rdata == {7'h00, $past(external_interrupt_line_0_enable_bit)})
      else $error("enable register read back wrong");

   routed_undriven_a: assert property ( // [R4]
      irq_pin_sel |-> !port1_drv.oe[PEIS_EXTERNAL_INTERRUPT_LINE_0_PIN])
      else $error("routed interrupt pin is driven");

   port1_view_a: assert property ( // [R5]
      reg_rd && hit(reg_addr, PEIS_OFS_P1_DATA)
      && port1_direction == PEIS_DIR_ALL_IN
      |=> reg_rdata == $past(port1_in))
      else $error("port 1 input read does not show the pins");

   port5_view_a: assert property ( // [R6]
      reg_rd && hit(reg_addr, PEIS_OFS_P5_DATA)
      && port5_direction == PEIS_DIR_ALL_OUT
      |=> reg_rdata == $past(port5_data))
      else $error("port 5 output read does not show the latch");

   port7_write_a: assert property (
      reg_wr && hit(reg_addr, PEIS_OFS_P7_DATA)
      |=> port7_out == $past(reg_wdata))
      else $error("port 7 write did not reach the pins");

   // Idle zero lets read data of several blocks be or-ed together
   rdata_idle_a: assert property (
      !reg_rd |=> reg_rdata == PEIS_RD_UNMAPPED)
      else $error("read data not zero outside a read");

endmodule

`default_nettype wire
